// ==== rtl/rph_regs.vh ====
`ifndef RPH_REGS_VH
`define RPH_REGS_VH
// Preamble byte, an alternating one-zero pattern sent MSB first.
`define RPH_PREAMBLE_BYTE 8'haa
// Whitening generator seed, all ones.
`define RPH_PN9_SEED 9'h1ff
// Feedback tap of the whitening generator, x^9 + x^5 + 1.
`define RPH_PN9_TAP 5
// Checksum polynomial x^16 + x^15 + x^2 + 1 and its seed.
`define RPH_CRC_POLY 16'h8005
`define RPH_CRC_SEED 16'hffff
// Checksum residue after the two checksum bytes of a good packet.
`define RPH_CRC_GOOD 16'h0000
// Sync qualifier match field values (low two bits of the mode).
`define RPH_SYNC_NONE 2'h0
`define RPH_SYNC_15OF16 2'h1
`define RPH_SYNC_16OF16 2'h2
`define RPH_SYNC_30OF32 2'h3
// Carrier sense gate bit of the sync qualifier mode.
`define RPH_SYNC_CS_BIT 2
// Correlation thresholds in matching bits.
`define RPH_THR_15 6'h0f
`define RPH_THR_16 6'h10
`define RPH_THR_30 6'h1e
// Preamble quality step down on a repeated bit.
`define RPH_PQ_DOWN 8'h08
// Length configuration values.
`define RPH_LEN_FIXED 1'b0
`define RPH_LEN_VAR 1'b1
// Address check values.
`define RPH_ADR_OFF 2'h0
`define RPH_ADR_BC0 2'h2
`define RPH_ADR_BC1 2'h3
// Broadcast addresses.
`define RPH_BCAST_LOW 8'h00
`define RPH_BCAST_HIGH 8'hff
// Last index of the sync byte sequence for two and four bytes.
`define RPH_SYNC_LAST2 2'h1
`define RPH_SYNC_LAST4 2'h3
// Last bit index within a byte.
`define RPH_BIT_LAST 3'h7
`endif

// ==== rtl/rph_pair_buffer.v ====
`timescale 1ns/1ps
// Two-entry byte buffer with valid and ready on both sides.
module rph_pair_buffer
(
	input wire mclk,
	input wire reset_n,
	input wire [7:0] inData,
	input wire inValid,
	output wire inReady,
	output wire [7:0] outData,
	output wire outValid,
	input wire outReady
);
	// Storage for the two entries.
	reg [7:0] mem [0:1];
	// Write pointer, read pointer and fill level.
	reg wrPtr_ff;
	reg rdPtr_ff;
	reg [1:0] count_ff;
	wire doWrite;
	wire doRead;

	// Full refuses the writer, empty hides data from the reader.
	assign inReady = (count_ff != 2'h2);
	assign outValid = (count_ff != 2'h0);
	assign outData = mem[rdPtr_ff];
	assign doWrite = inValid & inReady;
	assign doRead = outValid & outReady;

	// Pointers and level move on accepted transfers only.
	always @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wrPtr_ff <= 1'b0;
			rdPtr_ff <= 1'b0;
			count_ff <= 2'h0;
		end
		else
		begin
			if (doWrite)
				wrPtr_ff <= ~wrPtr_ff;
			if (doRead)
				rdPtr_ff <= ~rdPtr_ff;
			if (doWrite & ~doRead)
				count_ff <= count_ff + 2'h1;
			else if (doRead & ~doWrite)
				count_ff <= count_ff - 2'h1;
		end
	end

	// Entry storage needs no reset; it is read only while valid.
	always @(posedge mclk)
	begin
		if (doWrite)
			mem[wrPtr_ff] <= inData;
	end
endmodule // rph_pair_buffer

// ==== rtl/rph_packet_handler.v ====
`timescale 1ns/1ps
// Function
// R1: Sync word inserted each packet, optionally doubled.
// R2: Sync detect at 15/16, 16/16, 30/32.
// R3: Sync from high/low bytes, MSB first.
// R4: Preamble quality must pass before sync accepted.
// R5: Preamble and sync always sent together.
// R6: First status byte carries captured signal strength.
// R7: Second status byte: CRC good, link quality.
// R8: Whitening XORs data with nine-bit sequence.
// R9: Whitening generator seeded all ones per packet.
// R10: Software enables whitening only without legacy mode.
// R11: Alternating preamble, minimum byte count programmable.
// R12: Keep sending preamble until first byte written; a byte written after 15 preamble bytes is never sent if numPreamble > 0.
// R13: Modes 3 and 7 repeat sync twice.
// R14: Packet lengths up to 255 bytes.
// R15: Length field 0 uses fixed length register.
// R16: Length field 1: first byte gives length.
// R17: Oversize length discarded, done without DMA.
// R18: Address check with optional broadcast addresses.
// R19: Match accepts with DMA; mismatch discards, done only.
// R20: Transmit CRC over payload, two bytes after.
// R21: Underflow sets flags until idle strobe.
// R22: Whitening precedes error correction after sync.
// R23: Three-bit sync mode, upper half gated by carrier.
// R24: Quality counter +1 toggle, -8 repeat, 4x threshold.
// R25: Software changes configuration only while idle.
// R26: Whitening LFSR x^9+x^5+1, one step per bit.
// R27: CRC-16 x^16+x^15+x^2+1 seeded all ones.
`include "rph_regs.vh"
module rph_packet_handler
(
	input wire mclk,
	input wire reset_n,
	input wire [7:0] syncWordHigh,
	input wire [7:0] syncWordLow,
	input wire [2:0] syncMode,
	input wire [3:0] numPreamble,
	input wire [2:0] preambleQualityThreshold,
	input wire [7:0] packetLength,
	input wire lengthConfig,
	input wire [1:0] addressCheckMode,
	input wire [7:0] nodeAddress,
	input wire crcEnable,
	input wire appendStatus,
	input wire whiteningEnable,
	input wire errorCorrectionEnable,
	input wire txStart,
	input wire idleStrobe,
	input wire rxEnable,
	input wire [7:0] wrData,
	input wire wrValid,
	output wire wrReady,
	output wire txBit,
	output wire txBitValid,
	input wire txBitReady,
	output wire fecActive,
	input wire rxBit,
	input wire rxBitValid,
	input wire carrierSense,
	input wire [7:0] rssiValue,
	input wire [6:0] linkQualityValue,
	output reg [7:0] rxData_ff,
	output reg rxDataValid_ff,
	output reg dmaTrigger_ff,
	output reg doneFlag_ff,
	output reg txUnderflowFlag_ff,
	output reg preambleQualityReached_ff,
	output wire txBusy
);
	// Transmit states.
	localparam TX_IDLE = 6'h01;
	localparam TX_PRE = 6'h02;
	localparam TX_SYNC = 6'h04;
	localparam TX_DATA = 6'h08;
	localparam TX_CRC = 6'h10;
	localparam TX_UNDER = 6'h20;
	// Receive states.
	localparam RX_SRCH = 5'h01;
	localparam RX_LEN = 5'h02;
	localparam RX_PAY = 5'h04;
	localparam RX_CRC = 5'h08;
	localparam RX_STAT = 5'h10;

	// One whitening step; the output bit is pn[0].
	function [8:0] pn_step;
		input [8:0] pn;
		begin
			pn_step = {pn[0] ^ pn[`RPH_PN9_TAP], pn[8:1]}; // R26
		end
	endfunction

	// One checksum step over one data bit.
	function [15:0] crc_step;
		input [15:0] crc;
		input bitIn;
		begin
			crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ bitIn) ? `RPH_CRC_POLY : 16'h0000); // R27
		end
	endfunction

	// Count of set bits in a 32-bit vector.
	function [5:0] ones32;
		input [31:0] v;
		integer i;
		begin
			ones32 = 6'h00;
			for (i = 0; i < 32; i = i + 1)
				ones32 = ones32 + {5'h00, v[i]};
		end
	endfunction

	// Transmit registers.
	reg [5:0] txState_ff;
	reg [7:0] txSh_ff; // Byte being shifted out, MSB first.
	reg [2:0] txBitCnt_ff;
	reg [3:0] txPreCnt_ff; // Preamble bytes already sent, held at 15 once reached.
	reg [1:0] txSyncIdx_ff;
	reg [8:0] txLeft_ff; // Data bytes still to send after the current one.
	reg txCrcIdx_ff;
	reg [7:0] txCrcLow_ff;
	reg [8:0] txPn_ff;
	reg [15:0] txCrc_ff;
	// Receive registers.
	reg [4:0] rxState_ff;
	reg [31:0] rxWin_ff; // Correlation window of raw bits.
	reg rxPrev_ff;
	reg [7:0] pqCnt_ff;
	reg [7:0] rxSh_ff;
	reg [2:0] rxBitCnt_ff;
	reg [8:0] rxPn_ff;
	reg [15:0] rxCrc_ff;
	reg [8:0] rxLeft_ff;
	reg rxFirst_ff; // Next payload byte is the address byte.
	reg rxCrcIdx_ff;
	reg rxStIdx_ff;
	reg rxCrcOk_ff;
	reg [7:0] rssiHold_ff;

	// Buffer drain side.
	wire [7:0] bufData;
	wire bufValid;
	wire bufReady;
	// Transmit helpers.
	wire txBitTaken = txBitValid & txBitReady;
	wire txByteEnd = txBitTaken & (txBitCnt_ff == `RPH_BIT_LAST);
	wire txWhiteRegion = (txState_ff == TX_DATA) | (txState_ff == TX_CRC);
	wire doubleSync = (syncMode[1:0] == `RPH_SYNC_30OF32); // R13
	wire [1:0] syncLast = doubleSync ? `RPH_SYNC_LAST4 : `RPH_SYNC_LAST2;
	wire [15:0] txCrcNow = crc_step(txCrc_ff, txSh_ff[7]);
	wire [3:0] txPreNext = txPreCnt_ff + 4'h1;

	// Write path buffer; a stalled framer pushes back on the writer.
	rph_pair_buffer u_buf
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.inData(wrData),
		.inValid(wrValid),
		.inReady(wrReady),
		.outData(bufData),
		.outValid(bufValid),
		.outReady(bufReady)
	);

	// Bytes are pulled at the end of the last sync byte and of each data byte but the last.
	assign bufReady = txByteEnd & (((txState_ff == TX_SYNC) & (txSyncIdx_ff == syncLast))
		| ((txState_ff == TX_DATA) & (txLeft_ff != 9'h000))); // R20
	assign txBitValid = (txState_ff == TX_PRE) | (txState_ff == TX_SYNC) | txWhiteRegion;
	// Whitened bit goes to the coder stage, which follows whitening.
	assign txBit = txSh_ff[7] ^ (whiteningEnable & txWhiteRegion & txPn_ff[0]); // R8 R22
	assign fecActive = errorCorrectionEnable & txWhiteRegion; // R22
	assign txBusy = (txState_ff != TX_IDLE);

	// Transmit framer: preamble, sync, data, checksum, underflow.
	always @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			txState_ff <= TX_IDLE;
			txSh_ff <= 8'h00;
			txBitCnt_ff <= 3'h0;
			txPreCnt_ff <= 4'h0;
			txSyncIdx_ff <= 2'h0;
			txLeft_ff <= 9'h000;
			txCrcIdx_ff <= 1'b0;
			txCrcLow_ff <= 8'h00;
			txPn_ff <= `RPH_PN9_SEED;
			txCrc_ff <= `RPH_CRC_SEED;
			txUnderflowFlag_ff <= 1'b0;
		end
		else if (idleStrobe)
		begin
			// The idle strobe ends any transmission and clears underflow.
			txState_ff <= TX_IDLE; // R21
			txUnderflowFlag_ff <= 1'b0;
		end
		else
		begin
			if (txBitTaken)
			begin
				txBitCnt_ff <= txBitCnt_ff + 3'h1;
				txSh_ff <= {txSh_ff[6:0], 1'b0};
				if (txWhiteRegion)
					txPn_ff <= pn_step(txPn_ff); // R26
				if (txState_ff == TX_DATA)
					txCrc_ff <= txCrcNow; // R20
			end
			case (txState_ff)
				TX_IDLE:
				begin
					// Start always begins with preamble, never sync alone.
					if (txStart)
					begin
						txState_ff <= TX_PRE; // R5
						txSh_ff <= `RPH_PREAMBLE_BYTE; // R11
						txBitCnt_ff <= 3'h0;
						txPreCnt_ff <= 4'h0;
					end
				end
				TX_PRE:
				begin
					// Sync follows only once the minimum is sent and a byte waits.
					if (txByteEnd)
					begin
						if (txPreCnt_ff != 4'hf)
							txPreCnt_ff <= txPreNext;
						if ((txPreNext >= numPreamble) & bufValid) // R12
						begin
							txState_ff <= TX_SYNC; // R1 R5
							txSh_ff <= syncWordHigh; // R3
							txSyncIdx_ff <= 2'h0;
						end
						else
							txSh_ff <= `RPH_PREAMBLE_BYTE; // R11 R12
					end
				end
				TX_SYNC:
				begin
					// High then low byte, repeated when the long sync is selected.
					if (txByteEnd)
					begin
						if (txSyncIdx_ff != syncLast)
						begin
							txSyncIdx_ff <= txSyncIdx_ff + 2'h1;
							txSh_ff <= txSyncIdx_ff[0] ? syncWordHigh : syncWordLow; // R3 R13
						end
						else
						begin
							txState_ff <= TX_DATA;
							txSh_ff <= bufData;
							txPn_ff <= `RPH_PN9_SEED; // R9
							txCrc_ff <= `RPH_CRC_SEED; // R27
							if (lengthConfig == `RPH_LEN_VAR)
								txLeft_ff <= {1'b0, bufData}; // R16
							else
								txLeft_ff <= {1'b0, packetLength} - 9'h001; // R15 R14
						end
					end
				end
				TX_DATA:
				begin
					// Next byte, checksum, or underflow when the writer fell behind.
					if (txByteEnd)
					begin
						if (txLeft_ff != 9'h000)
						begin
							if (bufValid)
							begin
								txSh_ff <= bufData;
								txLeft_ff <= txLeft_ff - 9'h001;
							end
							else
							begin
								txState_ff <= TX_UNDER; // R21
								txUnderflowFlag_ff <= 1'b1; // R21
							end
						end
						else if (crcEnable)
						begin
							txState_ff <= TX_CRC; // R20
							txSh_ff <= txCrcNow[15:8];
							txCrcLow_ff <= txCrcNow[7:0];
							txCrcIdx_ff <= 1'b0;
						end
						else
							txState_ff <= TX_IDLE;
					end
				end
				TX_CRC:
				begin
					// Two checksum bytes, high byte first.
					if (txByteEnd)
					begin
						if (!txCrcIdx_ff)
						begin
							txCrcIdx_ff <= 1'b1;
							txSh_ff <= txCrcLow_ff; // R20
						end
						else
							txState_ff <= TX_IDLE;
					end
				end
				TX_UNDER:
				begin
					// Held here until the idle strobe.
					txState_ff <= TX_UNDER; // R21
				end
				default:
				begin
					txState_ff <= TX_IDLE;
				end
			endcase
		end
	end

	// Receive helpers.
	wire rxTake = rxBitValid & rxEnable;
	wire [31:0] winNext = {rxWin_ff[30:0], rxBit};
	wire [31:0] sync32 = {syncWordHigh, syncWordLow, syncWordHigh, syncWordLow}; // R13
	wire [31:0] agree = ~(winNext ^ sync32);
	wire [5:0] agree16 = ones32({16'h0000, agree[15:0]});
	wire [5:0] agree32 = ones32(agree);
	reg syncHit;
	wire pqOk = (preambleQualityThreshold == 3'h0)
		| (pqCnt_ff > {3'h0, preambleQualityThreshold, 2'h0}); // R24
	wire csOk = ~syncMode[`RPH_SYNC_CS_BIT] | carrierSense; // R23
	wire syncAccept = syncHit & pqOk & csOk; // R4 R23
	wire dBit = rxBit ^ (whiteningEnable & rxPn_ff[0]); // R8
	wire [7:0] byteNow = {rxSh_ff[6:0], dBit};
	wire rxByteEnd = rxTake & (rxBitCnt_ff == `RPH_BIT_LAST);
	wire [15:0] rxCrcNow = crc_step(rxCrc_ff, dBit);
	wire adrOk = (byteNow == nodeAddress)
		| ((addressCheckMode == `RPH_ADR_BC0) & (byteNow == `RPH_BCAST_LOW))
		| ((addressCheckMode == `RPH_ADR_BC1)
		& ((byteNow == `RPH_BCAST_LOW) | (byteNow == `RPH_BCAST_HIGH))); // R18

	// Correlator threshold chosen by the low bits of the mode.
	always @*
	begin
		case (syncMode[1:0])
			`RPH_SYNC_15OF16: syncHit = (agree16 >= `RPH_THR_15); // R2
			`RPH_SYNC_16OF16: syncHit = (agree16 >= `RPH_THR_16); // R2
			`RPH_SYNC_30OF32: syncHit = (agree32 >= `RPH_THR_30); // R2
			default: syncHit = 1'b1;
		endcase
	end

	// Receive deframer: search, length, payload, checksum, status.
	always @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rxState_ff <= RX_SRCH;
			rxWin_ff <= 32'h00000000;
			rxPrev_ff <= 1'b0;
			pqCnt_ff <= 8'h00;
			rxSh_ff <= 8'h00;
			rxBitCnt_ff <= 3'h0;
			rxPn_ff <= `RPH_PN9_SEED;
			rxCrc_ff <= `RPH_CRC_SEED;
			rxLeft_ff <= 9'h000;
			rxFirst_ff <= 1'b0;
			rxCrcIdx_ff <= 1'b0;
			rxStIdx_ff <= 1'b0;
			rxCrcOk_ff <= 1'b1;
			rssiHold_ff <= 8'h00;
			rxData_ff <= 8'h00;
			rxDataValid_ff <= 1'b0;
			dmaTrigger_ff <= 1'b0;
			doneFlag_ff <= 1'b0;
			preambleQualityReached_ff <= 1'b0;
		end
		else
		begin
			rxDataValid_ff <= 1'b0;
			dmaTrigger_ff <= 1'b0;
			// Done pulses for a transmit end or entry to underflow.
			doneFlag_ff <= txByteEnd & (((txState_ff == TX_CRC) & txCrcIdx_ff)
				| ((txState_ff == TX_DATA) & (txLeft_ff == 9'h000) & ~crcEnable)
				| ((txState_ff == TX_DATA) & (txLeft_ff != 9'h000) & ~bufValid)); // R21
			preambleQualityReached_ff <= pqOk;
			if (rxTake & (rxState_ff != RX_SRCH))
			begin
				rxBitCnt_ff <= rxBitCnt_ff + 3'h1;
				rxSh_ff <= byteNow;
				rxPn_ff <= pn_step(rxPn_ff); // R8 R26
				if (rxState_ff != RX_CRC)
					rxCrc_ff <= rxCrcNow;
			end
			if (!rxEnable)
				rxState_ff <= RX_SRCH;
			else
			case (rxState_ff)
				RX_SRCH:
				begin
					// Quality counter and correlator run on raw bits.
					if (rxTake)
					begin
						rxWin_ff <= winNext;
						rxPrev_ff <= rxBit;
						if (rxBit != rxPrev_ff)
						begin
							if (pqCnt_ff != 8'hff)
								pqCnt_ff <= pqCnt_ff + 8'h01; // R24
						end
						else if (pqCnt_ff > `RPH_PQ_DOWN)
							pqCnt_ff <= pqCnt_ff - `RPH_PQ_DOWN; // R24
						else
							pqCnt_ff <= 8'h00; // R24
					end
					if ((rxTake & syncAccept) | (syncMode[1:0] == `RPH_SYNC_NONE) & csOk)
					begin
						rxState_ff <= (lengthConfig == `RPH_LEN_VAR) ? RX_LEN : RX_PAY;
						rxLeft_ff <= {1'b0, packetLength}; // R15
						rxFirst_ff <= (addressCheckMode != `RPH_ADR_OFF);
						rxBitCnt_ff <= 3'h0;
						rxPn_ff <= `RPH_PN9_SEED; // R9
						rxCrc_ff <= `RPH_CRC_SEED; // R27
						rxCrcIdx_ff <= 1'b0;
						rxStIdx_ff <= 1'b0;
						rxWin_ff <= 32'h00000000;
						pqCnt_ff <= 8'h00;
						rssiHold_ff <= rssiValue; // R6
					end
				end
				RX_LEN:
				begin
					// Oversize lengths are dropped without any byte delivered.
					if (rxByteEnd)
					begin
						if (byteNow > packetLength)
						begin
							rxState_ff <= RX_SRCH; // R17
							doneFlag_ff <= 1'b1; // R17
						end
						else
						begin
							rxData_ff <= byteNow; // R16
							rxDataValid_ff <= 1'b1;
							dmaTrigger_ff <= 1'b1;
							rxLeft_ff <= {1'b0, byteNow}; // R16 R14
							rxState_ff <= (byteNow == 8'h00)
								? (crcEnable ? RX_CRC : (appendStatus ? RX_STAT : RX_SRCH))
								: RX_PAY;
							doneFlag_ff <= (byteNow == 8'h00) & ~crcEnable & ~appendStatus;
						end
					end
				end
				RX_PAY:
				begin
					// Address byte filters the packet; others are delivered.
					if (rxByteEnd)
					begin
						rxFirst_ff <= 1'b0;
						if (rxFirst_ff & ~adrOk)
						begin
							rxState_ff <= RX_SRCH; // R19
							doneFlag_ff <= 1'b1; // R19
						end
						else
						begin
							rxData_ff <= byteNow;
							rxDataValid_ff <= 1'b1; // R19
							dmaTrigger_ff <= 1'b1; // R19
							rxLeft_ff <= rxLeft_ff - 9'h001;
							if (rxLeft_ff <= 9'h001)
							begin
								rxState_ff <= crcEnable ? RX_CRC
									: (appendStatus ? RX_STAT : RX_SRCH);
								doneFlag_ff <= ~crcEnable & ~appendStatus;
							end
						end
					end
				end
				RX_CRC:
				begin
					// Checksum bytes run through the checker; residue zero is good.
					if (rxTake)
						rxCrc_ff <= rxCrcNow;
					if (rxByteEnd)
					begin
						rxCrcIdx_ff <= 1'b1;
						if (rxCrcIdx_ff)
						begin
							rxCrcOk_ff <= (rxCrcNow == `RPH_CRC_GOOD); // R7 R27
							rxState_ff <= appendStatus ? RX_STAT : RX_SRCH;
							doneFlag_ff <= ~appendStatus;
						end
					end
				end
				RX_STAT:
				begin
					// Signal strength byte, then checksum flag with link quality.
					rxStIdx_ff <= 1'b1;
					rxDataValid_ff <= 1'b1;
					dmaTrigger_ff <= 1'b1;
					if (!rxStIdx_ff)
						rxData_ff <= rssiHold_ff; // R6
					else
					begin
						rxData_ff <= {rxCrcOk_ff | ~crcEnable, linkQualityValue}; // R7
						rxState_ff <= RX_SRCH;
						doneFlag_ff <= 1'b1;
					end
				end
				default:
				begin
					rxState_ff <= RX_SRCH;
				end
			endcase
		end
	end
endmodule // rph_packet_handler

// ==== testbench/rph_air_model.sv ====
`timescale 1ns/1ps
// Remote radio: half-rate bit sink and raw bit source.
module rph_air_model
(
	input wire mclk,
	input wire clr,
	input wire stall,
	input wire txBit,
	input wire txBitValid,
	output wire txBitReady,
	output reg rxBit,
	output reg rxBitValid
);
	reg cap [0:2047]; // Bits taken off the air, oldest first.
	integer cnt = 0; // Count of bits taken.
	reg ph = 1'b0; // Alternates so that a bit is taken every other cycle.
	// A stalled sink takes nothing, so the framer must hold its bit.
	assign txBitReady = ~stall & ph;
	// Each taken bit is stored in arrival order.
	always @(posedge mclk)
	begin
		ph <= ~ph;
		if (clr)
			cnt <= 0;
		else if (txBitValid && txBitReady)
		begin
			cap[cnt] <= txBit;
			cnt <= cnt + 1;
		end
	end
	initial {rxBit, rxBitValid} = 2'b00;
	// Sends one byte MSB first; after the last byte the idle line shows the inverse bit.
	task send_byte(input [7:0] b, input last);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1)
			begin
				rxBit = b[i];
				rxBitValid = 1'b1;
				@(posedge mclk);
				#1;
			end
			if (last)
				{rxBitValid, rxBit} = {1'b0, ~rxBit};
		end
	endtask
endmodule // rph_air_model

// ==== testbench/rph_packet_props.sv ====
`timescale 1ns/1ps
// Framer control and flag timing.
module rph_packet_props
(
	input wire mclk,
	input wire reset_n,
	input wire txStart,
	input wire idleStrobe,
	input wire txBit,
	input wire txBitValid,
	input wire txBitReady,
	input wire fecActive,
	input wire rxDataValid_ff,
	input wire dmaTrigger_ff,
	input wire doneFlag_ff,
	input wire txUnderflowFlag_ff,
	input wire txBusy
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_dma_with_data: assert property (dmaTrigger_ff |-> rxDataValid_ff)
		else $error("dma trigger without a delivered byte");
	a_bit_stands: assert property (txBitValid && !txBitReady && !idleStrobe
		|=> txBitValid && $stable(txBit)) else $error("air bit changed while stalled");
	a_start_preamble: assert property (txStart && !txBusy |=> txBitValid && txBit)
		else $error("transmit did not open with a preamble one");
	a_preamble_uncoded: assert property (txStart && !txBusy |=> !fecActive)
		else $error("preamble marked as coded");
	a_idle_silent: assert property (!txBusy |-> !txBitValid)
		else $error("air bit offered while idle");
	a_unf_holds: assert property (txUnderflowFlag_ff && !idleStrobe |=> txUnderflowFlag_ff)
		else $error("underflow cleared without idle strobe");
	a_unf_clears: assert property (idleStrobe |=> !txUnderflowFlag_ff)
		else $error("underflow kept after idle strobe");
	a_unf_quiet: assert property (txUnderflowFlag_ff |-> !txBitValid)
		else $error("air bits offered during underflow");
	a_unf_done: assert property ($rose(txUnderflowFlag_ff) |-> doneFlag_ff)
		else $error("underflow without done");
endmodule // rph_packet_props
bind rph_packet_handler rph_packet_props i_rph_packet_props (.mclk, .reset_n, .txStart,
	.idleStrobe, .txBit, .txBitValid, .txBitReady, .fecActive, .rxDataValid_ff,
	.dmaTrigger_ff, .doneFlag_ff, .txUnderflowFlag_ff, .txBusy);

// ==== testbench/rph_packet_handler_tb_top.sv ====
`timescale 1ns/1ps
// Framer bench.
module rph_packet_handler_tb_top;
	reg mclk = 0, reset_n = 0, lengthConfig = 0, crcEnable = 0, appendStatus = 0;
	reg whiteningEnable = 0, errorCorrectionEnable = 0, txStart = 0, idleStrobe = 0;
	reg rxEnable = 0, wrValid = 0, carrierSense = 1, stall = 0, clr = 0;
	reg [7:0] syncWordHigh = 8'h2d, syncWordLow = 8'hd4, packetLength = 8'h02;
	reg [7:0] nodeAddress = 8'h42, wrData = 8'h00, rssiValue = 8'h9b;
	reg [2:0] syncMode = 3'h2, preambleQualityThreshold = 3'h1;
	reg [3:0] numPreamble = 4'h2;
	reg [1:0] addressCheckMode = 2'h0;
	reg [6:0] linkQualityValue = 7'h35;
	wire wrReady, txBit, txBitValid, txBitReady, fecActive, rxBit, rxBitValid;
	wire rxDataValid_ff, dmaTrigger_ff, doneFlag_ff, txUnderflowFlag_ff, txBusy;
	wire preambleQualityReached_ff;
	wire [7:0] rxData_ff;
	integer err_count = 0, checks = 0, cyc = 0, nq = 0, nDone = 0, nDma = 0, ne, q0, t;
	reg [7:0] d [0:7]; // Packet bytes before framing.
	reg [7:0] ex [0:15]; // Framed bytes after the preamble.
	reg [7:0] rxq [0:255]; // Bytes delivered by the receiver.
	reg [8:0] pn; // Whitening sequence state.
	rph_packet_handler i_rph_packet_handler (.mclk, .reset_n, .syncWordHigh, .syncWordLow,
		.syncMode, .numPreamble, .preambleQualityThreshold, .packetLength, .lengthConfig,
		.addressCheckMode, .nodeAddress, .crcEnable, .appendStatus, .whiteningEnable,
		.errorCorrectionEnable, .txStart, .idleStrobe, .rxEnable, .wrData, .wrValid, .wrReady,
		.txBit, .txBitValid, .txBitReady, .fecActive, .rxBit, .rxBitValid, .carrierSense,
		.rssiValue, .linkQualityValue, .rxData_ff, .rxDataValid_ff, .dmaTrigger_ff,
		.doneFlag_ff, .txUnderflowFlag_ff, .preambleQualityReached_ff, .txBusy);
	rph_air_model i_rph_air_model (.mclk, .clr, .stall, .txBit, .txBitValid, .txBitReady,
		.rxBit, .rxBitValid);
	// Free-running 50 MHz clock.
	initial forever #10 mclk = ~mclk;
	// Collects deliveries and counts flags; a hang is cut short here.
	always @(posedge mclk)
	begin
		cyc = cyc + 1;
		if (rxDataValid_ff === 1'b1)
		begin
			rxq[nq] = rxData_ff;
			nq = nq + 1;
		end
		nDma = nDma + (dmaTrigger_ff === 1'b1);
		nDone = nDone + (doneFlag_ff === 1'b1);
		if (cyc == 20000)
		begin
			err_count = err_count + 1;
			close_out;
		end
	end
	// Prints the verdict and ends the run.
	task close_out;
		begin
			if (err_count == 0 && checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// Compares one value and reports a difference.
	task chk(input string nm, input [15:0] s, input [15:0] e);
		begin
			checks = checks + 1;
			if (s !== e)
			begin
				err_count = err_count + 1;
				$display("BAD %0s exp %h seen %h", nm, e, s);
			end
		end
	endtask
	// Inputs move one nanosecond after the rising edge.
	task tick;
		begin
			@(posedge mclk);
			#1;
		end
	endtask
	// Writes one byte; the caller lowers valid after the last one.
	task wr(input [7:0] b);
		begin
			wrData = b;
			wrValid = 1'b1;
			t = 0;
			while (wrReady !== 1'b1 && t < 2000)
			begin
				tick;
				t = t + 1;
			end
			tick;
		end
	endtask
	// One checksum step over a byte, MSB first.
	function [15:0] crcb(input [15:0] c, input [7:0] b);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h8005 : 16'h0000);
			crcb = c;
		end
	endfunction
	// Whitens a byte in place when whitening is on, advancing the sequence per bit.
	task whb(inout [7:0] b);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1)
			begin
				b[i] = b[i] ^ (pn[0] & whiteningEnable);
				pn = {pn[0] ^ pn[5], pn[8:1]};
			end
		end
	endtask
	// Builds sync, n packet bytes and checksum as they must appear on the air.
	task build(input integer n, input integer ns);
		integer i;
		reg [15:0] c;
		reg [7:0] b;
		begin
			ex[0] = syncWordHigh;
			ex[1] = syncWordLow;
			ex[2] = syncWordHigh;
			ex[3] = syncWordLow;
			ne = ns;
			pn = 9'h1ff;
			c = 16'hffff;
			for (i = 0; i < n + 2 * crcEnable; i = i + 1)
			begin
				b = (i < n) ? d[i] : (i == n) ? c[15:8] : c[7:0];
				if (i < n)
					c = crcb(c, d[i]);
				whb(b);
				ex[ne] = b;
				ne = ne + 1;
			end
		end
	endtask
	// Reads one captured air byte.
	function [7:0] cb(input integer p);
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1)
				cb = {cb[6:0], i_rph_air_model.cap[p + i]};
		end
	endfunction
	// Waits for the transmitter to go idle, then checks preamble and frame.
	task txchk(input integer exact);
		integer k, i;
		begin
			t = 0;
			while (txBusy !== 1'b0 && t < 3000)
			begin
				tick;
				t = t + 1;
			end
			k = 0;
			while (cb(8 * k) === 8'haa && k < 64)
				k = k + 1;
			chk("pre", exact ? k : (k > numPreamble), exact ? numPreamble : 1);
			for (i = 0; i < ne; i = i + 1)
				chk("txbyte", cb(8 * (k + i)), ex[i]);
			chk("nbits", i_rph_air_model.cnt, 8 * (k + ne));
		end
	endtask
	// Sends preamble and a built frame, then checks what the receiver delivered.
	task rx(input integer n, input integer ns, input [15:0] sx, input bad, input acc);
		integer i, dn0, dm0;
		begin
			build(n, ns);
			ex[0] = ex[0] ^ sx[15:8];
			ex[1] = ex[1] ^ sx[7:0];
			ex[ne - 1] = ex[ne - 1] ^ {7'h00, bad};
			q0 = nq;
			dn0 = nDone;
			dm0 = nDma;
			repeat (4) i_rph_air_model.send_byte(8'haa, 1'b0);
			chk("pqr", preambleQualityReached_ff, 1);
			for (i = 0; i < ne; i = i + 1)
				i_rph_air_model.send_byte(ex[i], i == ne - 1);
			t = 0;
			while (nDone == dn0 && t < 300)
			begin
				tick;
				t = t + 1;
			end
			tick;
			chk("ndone", nDone - dn0, 1);
			chk("nrx", nq - q0, acc ? n + 2 * appendStatus : 0);
			chk("ndma", nDma - dm0, acc ? n + 2 * appendStatus : 0);
			for (i = 0; i < n && acc; i = i + 1)
				chk("rxbyte", rxq[q0 + i], d[i]);
			if (acc && appendStatus)
			begin
				chk("rssi", rxq[q0 + n], rssiValue);
				chk("stat2", rxq[q0 + n + 1], {~bad, linkQualityValue});
			end
		end
	endtask
	// Main sequence; configuration is changed only while the radio is idle.
	initial
	begin
		repeat (10) @(posedge mclk);
		chk("rstready", wrReady, 1);
		chk("rstbusy", txBusy, 0);
		#1 reset_n = 1'b1;
		// Late first write: preamble runs on until it arrives.
		txStart = 1'b1;
		tick;
		txStart = 1'b0;
		repeat (60) tick;
		d[0] = 8'h12;
		d[1] = 8'h34;
		wr(d[0]);
		wr(d[1]);
		wrValid = 1'b0;
		build(2, 2);
		txchk(0);
		// Doubled sync, checksum, whitening; a stalled sink fills the buffer.
		syncMode = 3'h3;
		crcEnable = 1'b1;
		whiteningEnable = 1'b1;
		errorCorrectionEnable = 1'b1;
		syncWordHigh = 8'h91;
		clr = 1'b1;
		stall = 1'b1;
		tick;
		clr = 1'b0;
		txStart = 1'b1;
		tick;
		txStart = 1'b0;
		d[0] = 8'hc7;
		d[1] = 8'h00;
		wr(d[0]);
		wr(d[1]);
		wrValid = 1'b0;
		chk("full", wrReady, 0);
		stall = 1'b0;
		build(2, 4);
		txchk(1);
		chk("drained", wrReady, 1);
		// Too few bytes: underflow until the idle strobe.
		syncMode = 3'h2;
		packetLength = 8'h03;
		txStart = 1'b1;
		tick;
		txStart = 1'b0;
		wr(8'h55);
		wrValid = 1'b0;
		t = 0;
		while (txUnderflowFlag_ff !== 1'b1 && t < 3000)
		begin
			tick;
			t = t + 1;
		end
		chk("unf", txUnderflowFlag_ff, 1);
		idleStrobe = 1'b1;
		tick;
		idleStrobe = 1'b0;
		tick;
		chk("unfclr", {txUnderflowFlag_ff, txBusy}, 0);
		// Receive: variable length, broadcast address, status bytes.
		rxEnable = 1'b1;
		lengthConfig = 1'b1;
		packetLength = 8'h08;
		addressCheckMode = 2'h3;
		appendStatus = 1'b1;
		d[0] = 8'h02;
		d[1] = 8'hff;
		d[2] = 8'h5c;
		rx(3, 2, 16'h0000, 0, 1);
		syncMode = 3'h1;
		rssiValue = 8'h27;
		d[1] = 8'h00;
		rx(3, 2, 16'h0400, 1, 1);
		// Node address mismatch in fixed length mode.
		syncMode = 3'h2;
		lengthConfig = 1'b0;
		packetLength = 8'h02;
		addressCheckMode = 2'h1;
		appendStatus = 1'b0;
		whiteningEnable = 1'b0;
		d[0] = 8'h41;
		d[1] = 8'h77;
		rx(2, 2, 16'h0000, 0, 0);
		// Length byte above the maximum.
		lengthConfig = 1'b1;
		packetLength = 8'h03;
		d[0] = 8'h05;
		rx(3, 2, 16'h0000, 0, 0);
		// Thirty-two bit sync, carrier gated.
		syncMode = 3'h7;
		lengthConfig = 1'b0;
		packetLength = 8'h01;
		addressCheckMode = 2'h0;
		d[0] = 8'h9e;
		rx(1, 4, 16'h0000, 0, 1);
		close_out;
	end
endmodule // rph_packet_handler_tb_top
